// ==== include/dsf_pkg.sv ====
// Summary of operation
// - host ends frame after 24th/32nd fall
// - config frame: select high 198 ns
// - DAC update frame: select high 5 us
// - slew enabled: 20 us between frames
// - slew disabled: 5 us between frames
// - load strobe falls 20/5 us after select
// - device updates within 500 ns of strobe
// - strobe held low: update 5 us after select rise
// - strobe in frame: 500 ns before select
// - readback, falling first: 7 + 16 bits
// - readback, rising first: 8 + 16 bits
// - error check appends 8 CRC bits
// - error check, rising first: 32 bits
// - keep serial clock idle between frames
// - output bit valid 40 ns after rise
package dsf_pkg;
   localparam int          CLK_NS          = 5;
   localparam logic [5:0]  FRAME_LEN       = 6'h18;
   localparam logic [5:0]  FRAME_LEN_PEC   = 6'h20;
   localparam int          FLD_RD          = 23;
   localparam int          FLD_DAC         = 22;
   localparam logic [7:0]  CRC_POLY        = 8'h07;
   localparam int          CNT_W           = 13;
   typedef logic [CNT_W-1:0] dsf_cnt_t;
   // serial link times
   localparam int T_CFG_GAP_NS    = 198;
   localparam int T_DAC_GAP_US    = 5;
   localparam int T_SLEW_GAP_US   = 20;
   localparam int T_LOAD_RESP_NS  = 500;
   localparam int T_SYNC_UPD_US   = 5;
   localparam int T_SDO_VALID_NS  = 40;
   localparam int T_SYNC_HOLD_NS  = 13;
   localparam int T_LOAD_LOW_NS   = 10;
   localparam int CFG_GAP_CYC     = (T_CFG_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int DAC_GAP_CYC     = (T_DAC_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SLEW_GAP_CYC    = (T_SLEW_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int LOAD_RESP_CYC   = T_LOAD_RESP_NS / CLK_NS;
   localparam int SYNC_UPD_CYC    = (T_SYNC_UPD_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int SDO_VALID_CYC   = T_SDO_VALID_NS / CLK_NS;
   localparam int HOLD_CYC        = (T_SYNC_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOAD_LOW_CYC    = (T_LOAD_LOW_NS + CLK_NS - 1) / CLK_NS;
   // half period of the generated serial clock, long enough for a synced readback bit
   localparam int SCLK_HALF_CYC   = 13;
   // controller registers
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_TX    = 8'h04;
   localparam logic [7:0] REG_RX    = 8'h08;
   localparam logic [7:0] REG_STAT  = 8'h0C;
   localparam logic [7:0] REG_MASK  = 8'h10;
   localparam int CTRL_PEC        = 0;
   localparam int CTRL_SLEW       = 1;
   localparam int CTRL_LOAD_HELD  = 2;
   localparam int CTRL_LOAD_PULSE = 3;
   localparam int CTRL_CLEAR      = 4;
   localparam int CTRL_W          = 5;
   localparam int ST_FRAME        = 0;
   localparam int ST_READY        = 1;
   localparam int ST_CRC_ERR      = 2;
   localparam int ST_W            = 3;
   localparam int ST_BUSY         = 8;
   typedef enum logic [2:0] {
      HS_IDLE  = 3'b000,
      HS_SETUP = 3'b001,
      HS_LOW   = 3'b010,
      HS_HIGH  = 3'b011,
      HS_HOLD  = 3'b100,
      HS_GAP   = 3'b101,
      HS_LOAD  = 3'b110
   } dsf_hstate_t;

   function automatic logic [7:0] crc8_calc(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction : crc8_calc
endpackage : dsf_pkg

// ==== include/dsf_if.sv ====
`timescale 1ns/1ps
interface dsf_if;
   logic serialClk;
   logic frameSelN;
   logic serialIn;
   logic serialOut;
   logic loadOutputStrobeN;
   logic clearN;
   modport dev (
      input  serialClk,
      input  frameSelN,
      input  serialIn,
      input  loadOutputStrobeN,
      input  clearN,
      output serialOut
   );
   modport host (
      output serialClk,
      output frameSelN,
      output serialIn,
      output loadOutputStrobeN,
      output clearN,
      input  serialOut
   );
endinterface : dsf_if

// ==== src/dsf_device.sv ====
`timescale 1ns/1ps
module dsf_device (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // serial link
   dsf_if.dev               link,
   // user side
   input  wire logic        pecEnable,
   input  wire logic [15:0] readData,
   output logic      [15:0] dacCode,
   output logic             dacUpdated,
   output logic      [23:0] cfgWord,
   output logic             cfgValid,
   output logic             pecError
);
   typedef struct packed {
      logic [2:0]  sclkS;
      logic [2:0]  syncS;
      logic [2:0]  loadS;
      logic [1:0]  sdinS;
      logic [1:0]  clearS;
      logic [31:0] inSh;
      logic [5:0]  inCnt;
      logic [31:0] outSh;
      logic [15:0] rbData;
      logic        rbPend;
      logic [15:0] pendCode;
      logic        pend;
      logic [12:0] updCnt;
      logic        updRun;
      logic [15:0] dacCode;
      logic        dacUpd;
      logic [23:0] cfgWord;
      logic        cfgValid;
      logic        pecErr;
   } dsf_dev_st_t;

   dsf_dev_st_t s_r;
   dsf_dev_st_t s_nxt;

   always_comb begin
      logic [23:0] word;
      logic [15:0] rb;
      logic        sclkRise;
      logic        sclkFall;
      logic        syncFall;
      logic        syncRise;
      logic        loadFall;
      logic [7:0]  rbCrc;
      word = s_r.inSh[23:0];
      rb = s_r.rbPend ? s_r.rbData : 16'h0000;
      // crc trails the data only with error checking on, else the 24th bit is zero
      rbCrc = pecEnable ? dsf_pkg::crc8_calc({8'h00, rb}) : 8'h00;
      s_nxt = s_r;
      s_nxt.dacUpd = 1'b0;
      s_nxt.cfgValid = 1'b0;
      s_nxt.pecErr = 1'b0;
      // first flop of each chain feeds only the second
      s_nxt.sclkS = {s_r.sclkS[1:0], link.serialClk};
      s_nxt.syncS = {s_r.syncS[1:0], link.frameSelN};
      s_nxt.loadS = {s_r.loadS[1:0], link.loadOutputStrobeN};
      s_nxt.sdinS = {s_r.sdinS[0], link.serialIn};
      s_nxt.clearS = {s_r.clearS[0], link.clearN};
      sclkRise = s_r.sclkS[1] & ~s_r.sclkS[2];
      sclkFall = ~s_r.sclkS[1] & s_r.sclkS[2];
      syncFall = ~s_r.syncS[1] & s_r.syncS[2];
      syncRise = s_r.syncS[1] & ~s_r.syncS[2];
      loadFall = ~s_r.loadS[1] & s_r.loadS[2];
      if (syncFall) begin
         s_nxt.inCnt = 6'h00;
         s_nxt.rbPend = 1'b0;
         // clock idling high means the first edge falls: one don't-care bit fewer
         if (s_r.sclkS[1]) begin
            s_nxt.outSh = {7'h00, rb, rbCrc, 1'b0};
         end else begin
            s_nxt.outSh = {8'h00, rb, rbCrc};
         end
      end else if (~s_r.syncS[1]) begin
         if (sclkFall) begin
            s_nxt.inSh = {s_r.inSh[30:0], s_r.sdinS[1]};
            if (s_r.inCnt != 6'h3F) begin
               s_nxt.inCnt = s_r.inCnt + 6'h01;
            end
         end
         if (sclkRise) begin
            s_nxt.outSh = {s_r.outSh[30:0], 1'b0};
         end
      end
      if (syncRise) begin
         if (pecEnable) begin
            word = s_r.inSh[31:8];
         end
         if (s_r.inCnt == (pecEnable ? dsf_pkg::FRAME_LEN_PEC : dsf_pkg::FRAME_LEN)) begin
            if (pecEnable && dsf_pkg::crc8_calc(word) != s_r.inSh[7:0]) begin
               s_nxt.pecErr = 1'b1;
            end else if (word[dsf_pkg::FLD_DAC]) begin
               s_nxt.pendCode = word[15:0];
               if (~s_r.loadS[1]) begin
                  s_nxt.updRun = 1'b1;
                  s_nxt.updCnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::SYNC_UPD_CYC - 1);
               end else begin
                  s_nxt.pend = 1'b1;
               end
            end else if (word[dsf_pkg::FLD_RD]) begin
               s_nxt.rbData = readData;
               s_nxt.rbPend = 1'b1;
            end else if (word[23:16] != 8'h00) begin
               s_nxt.cfgWord = word;
               s_nxt.cfgValid = 1'b1;
            end
         end
      end
      if (s_r.pend && loadFall) begin
         s_nxt.dacCode = s_r.pendCode;
         s_nxt.pend = 1'b0;
         s_nxt.dacUpd = 1'b1;
      end
      if (s_r.updRun) begin
         if (s_r.updCnt == 13'h0000) begin
            s_nxt.dacCode = s_r.pendCode;
            s_nxt.updRun = 1'b0;
            s_nxt.dacUpd = 1'b1;
         end else begin
            s_nxt.updCnt = s_r.updCnt - 13'h0001;
         end
      end
      if (~s_r.clearS[1]) begin
         s_nxt.dacCode = 16'h0000;
         s_nxt.pend = 1'b0;
         s_nxt.updRun = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.sclkS <= '1;
         s_r.syncS <= '1;
         s_r.loadS <= '1;
         s_r.clearS <= '1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.serialOut = s_r.outSh[31];
   assign dacCode = s_r.dacCode;
   assign dacUpdated = s_r.dacUpd;
   assign cfgWord = s_r.cfgWord;
   assign cfgValid = s_r.cfgValid;
   assign pecError = s_r.pecErr;
endmodule : dsf_device

// ==== src/dsf_host.sv ====
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module dsf_host (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // interrupt
   output logic             irq,
   // serial link
   dsf_if.host              link
);
   typedef struct packed {
      logic [dsf_pkg::CTRL_W-1:0] ctrl;
      logic [dsf_pkg::ST_W-1:0]   mask;
      logic [dsf_pkg::ST_W-1:0]   stat;
      logic                       ack;
      logic [31:0]                rdat;
      dsf_pkg::dsf_hstate_t       state;
      logic [12:0]                cnt;
      logic [5:0]                 bitsLeft;
      logic [31:0]                txSh;
      logic [31:0]                rxSh;
      logic                       isDac;
      logic                       isRd;
      logic                       rbNow;
      logic [1:0]                 sdoS;
      logic                       sclk;
      logic                       syncN;
      logic                       loadN;
   } dsf_host_st_t;

   dsf_host_st_t s_r;
   dsf_host_st_t s_nxt;

   always_comb begin
      logic        access;
      logic        wrFull;
      logic        startTx;
      logic        setFrame;
      logic        setReady;
      logic        setCrc;
      logic [23:0] word;
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.sdoS = {s_r.sdoS[0], link.serialOut};
      access = cyc_i & stb_i & ~s_r.ack;
      wrFull = access & we_i & (sel_i == 4'hF);
      startTx = 1'b0;
      setFrame = 1'b0;
      setReady = 1'b0;
      setCrc = 1'b0;
      word = dat_i[23:0];
      if (access) begin
         s_nxt.ack = 1'b1;
         s_nxt.rdat = 32'h0000_0000;
         case (adr_i)
            dsf_pkg::REG_CTRL: begin
               if (wrFull) begin
                  s_nxt.ctrl = dat_i[dsf_pkg::CTRL_W-1:0];
               end
               s_nxt.rdat[dsf_pkg::CTRL_W-1:0] = s_r.ctrl;
            end
            dsf_pkg::REG_TX: begin
               // a frame request while busy is dropped
               startTx = wrFull & (s_r.state == dsf_pkg::HS_IDLE);
            end
            dsf_pkg::REG_RX: begin
               s_nxt.rdat = s_r.rxSh;
            end
            dsf_pkg::REG_STAT: begin
               s_nxt.rdat[dsf_pkg::ST_W-1:0] = s_r.stat;
               s_nxt.rdat[dsf_pkg::ST_BUSY] = (s_r.state != dsf_pkg::HS_IDLE);
               if (!we_i) begin
                  s_nxt.stat = '0;
               end
            end
            dsf_pkg::REG_MASK: begin
               if (wrFull) begin
                  s_nxt.mask = dat_i[dsf_pkg::ST_W-1:0];
               end
               s_nxt.rdat[dsf_pkg::ST_W-1:0] = s_r.mask;
            end
            default: begin
               s_nxt.rdat = 32'h0000_0000;
            end
         endcase
      end
      case (s_r.state)
         dsf_pkg::HS_IDLE: begin
            // clock parked high so no edges reach the device between frames
            s_nxt.sclk = 1'b1;
            s_nxt.syncN = 1'b1;
            if (startTx) begin
               if (s_r.ctrl[dsf_pkg::CTRL_PEC]) begin
                  s_nxt.txSh = {word, dsf_pkg::crc8_calc(word)};
                  s_nxt.bitsLeft = dsf_pkg::FRAME_LEN_PEC;
               end else begin
                  s_nxt.txSh = {word, 8'h00};
                  s_nxt.bitsLeft = dsf_pkg::FRAME_LEN;
               end
               s_nxt.isDac = word[dsf_pkg::FLD_DAC];
               s_nxt.isRd = word[dsf_pkg::FLD_RD];
               s_nxt.rbNow = s_r.isRd;
               s_nxt.rxSh = 32'h0000_0000;
               s_nxt.syncN = 1'b0;
               s_nxt.cnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::SCLK_HALF_CYC - 1);
               s_nxt.state = dsf_pkg::HS_SETUP;
            end
         end
         dsf_pkg::HS_SETUP, dsf_pkg::HS_HIGH: begin
            if (s_r.cnt == 13'h0000) begin
               // device takes the bit on this fall; readback bit sampled as well
               s_nxt.sclk = 1'b0;
               s_nxt.rxSh = {s_r.rxSh[30:0], s_r.sdoS[1]};
               s_nxt.bitsLeft = s_r.bitsLeft - 6'h01;
               s_nxt.cnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::SCLK_HALF_CYC - 1);
               s_nxt.state = dsf_pkg::HS_LOW;
            end else begin
               s_nxt.cnt = s_r.cnt - 13'h0001;
            end
         end
         dsf_pkg::HS_LOW: begin
            if (s_r.cnt == 13'h0000) begin
               s_nxt.sclk = 1'b1;
               if (s_r.bitsLeft == 6'h00) begin
                  s_nxt.cnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::HOLD_CYC - 1);
                  s_nxt.state = dsf_pkg::HS_HOLD;
               end else begin
                  s_nxt.txSh = {s_r.txSh[30:0], 1'b0};
                  s_nxt.cnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::SCLK_HALF_CYC - 1);
                  s_nxt.state = dsf_pkg::HS_HIGH;
               end
            end else begin
               s_nxt.cnt = s_r.cnt - 13'h0001;
            end
         end
         dsf_pkg::HS_HOLD: begin
            if (s_r.cnt == 13'h0000) begin
               s_nxt.syncN = 1'b1;
               setFrame = 1'b1;
               if (s_r.ctrl[dsf_pkg::CTRL_PEC] && s_r.rbNow &&
                   dsf_pkg::crc8_calc({8'h00, s_r.rxSh[24:9]}) != s_r.rxSh[8:1]) begin
                  setCrc = 1'b1;
               end
               if (!s_r.isDac) begin
                  s_nxt.cnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::CFG_GAP_CYC - 1);
               end else if (s_r.ctrl[dsf_pkg::CTRL_SLEW]) begin
                  s_nxt.cnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::SLEW_GAP_CYC - 1);
               end else begin
                  s_nxt.cnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::DAC_GAP_CYC - 1);
               end
               s_nxt.state = dsf_pkg::HS_GAP;
            end else begin
               s_nxt.cnt = s_r.cnt - 13'h0001;
            end
         end
         dsf_pkg::HS_GAP: begin
            if (s_r.cnt != 13'h0000) begin
               s_nxt.cnt = s_r.cnt - 13'h0001;
            end else if (s_r.isDac && s_r.ctrl[dsf_pkg::CTRL_LOAD_PULSE] &&
                         !s_r.ctrl[dsf_pkg::CTRL_LOAD_HELD]) begin
               // strobe only after the gap, never inside a frame
               s_nxt.loadN = 1'b0;
               s_nxt.cnt = dsf_pkg::dsf_cnt_t'(dsf_pkg::LOAD_LOW_CYC - 1);
               s_nxt.state = dsf_pkg::HS_LOAD;
            end else begin
               setReady = 1'b1;
               s_nxt.state = dsf_pkg::HS_IDLE;
            end
         end
         dsf_pkg::HS_LOAD: begin
            if (s_r.cnt == 13'h0000) begin
               s_nxt.loadN = 1'b1;
               setReady = 1'b1;
               s_nxt.state = dsf_pkg::HS_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt - 13'h0001;
            end
         end
         default: begin
            s_nxt.state = dsf_pkg::HS_IDLE;
            s_nxt.sclk = 1'b1;
            s_nxt.syncN = 1'b1;
         end
      endcase
      // strobe held low lets the device update 5 us after frame select rise
      if (s_nxt.state != dsf_pkg::HS_LOAD) begin
         s_nxt.loadN = ~s_nxt.ctrl[dsf_pkg::CTRL_LOAD_HELD];
      end
      // a new event wins over the read-clear in the same cycle
      s_nxt.stat[dsf_pkg::ST_FRAME] = s_nxt.stat[dsf_pkg::ST_FRAME] | setFrame;
      s_nxt.stat[dsf_pkg::ST_READY] = s_nxt.stat[dsf_pkg::ST_READY] | setReady;
      s_nxt.stat[dsf_pkg::ST_CRC_ERR] = s_nxt.stat[dsf_pkg::ST_CRC_ERR] | setCrc;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.sclk <= 1'b1;
         s_r.syncN <= 1'b1;
         s_r.loadN <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dat_o = s_r.rdat;
   assign ack_o = s_r.ack;
   assign irq = |(s_r.stat & s_r.mask);
   assign link.serialClk = s_r.sclk;
   assign link.frameSelN = s_r.syncN;
   assign link.serialIn = s_r.txSh[31];
   assign link.loadOutputStrobeN = s_r.loadN;
   assign link.clearN = ~s_r.ctrl[dsf_pkg::CTRL_CLEAR];
endmodule : dsf_host

// ==== verification/dsf_assertions.sv ====
`timescale 1ns/1ps
module dsf_assertions (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // link
   input wire logic serialClk,
   input wire logic frameSelN,
   input wire logic serialIn,
   input wire logic serialOut,
   input wire logic loadOutputStrobeN
);
   logic [5:0]  fallCnt_r;
   logic [12:0] hiCnt_r;
   logic [31:0] bits_r;
   logic [3:0]  age_r;
   logic        dacFrm_r;
   logic        clkQ_r;
   logic        selQ_r;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // hiCnt_r and age_r saturate so a long idle never wraps into a short gap
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         fallCnt_r <= 6'h00;
         hiCnt_r   <= 13'h1FFF;
         bits_r    <= 32'h0000_0000;
         age_r     <= 4'hF;
         dacFrm_r  <= 1'b0;
         clkQ_r    <= 1'b1;
         selQ_r    <= 1'b1;
      end else begin
         clkQ_r <= serialClk;
         selQ_r <= frameSelN;
         if (!frameSelN && clkQ_r && !serialClk) begin
            fallCnt_r <= fallCnt_r + 6'h01;
            bits_r    <= {bits_r[30:0], serialIn};
         end else if (frameSelN) begin
            fallCnt_r <= 6'h00;
         end
         if (frameSelN && !selQ_r) begin
            dacFrm_r <= (fallCnt_r == dsf_pkg::FRAME_LEN_PEC) ? bits_r[30] : bits_r[22];
         end
         hiCnt_r <= frameSelN ? hiCnt_r + 13'(~&hiCnt_r) : 13'h0000;
         age_r   <= ((!clkQ_r && serialClk) || (selQ_r && !frameSelN)) ? 4'h0
                    : age_r + 4'(~&age_r);
      end
   end

   frame_len_a:
      assert property ($rose(frameSelN) |->
         fallCnt_r == dsf_pkg::FRAME_LEN || fallCnt_r == dsf_pkg::FRAME_LEN_PEC)
      else $error("frame closed after a wrong clock count");
   cfg_gap_a:
      assert property ($fell(frameSelN) |-> hiCnt_r >= 13'(dsf_pkg::CFG_GAP_CYC))
      else $error("select high time too short");
   dac_gap_a:
      assert property ($fell(frameSelN) && dacFrm_r |-> hiCnt_r >= 13'(dsf_pkg::DAC_GAP_CYC))
      else $error("gap after dac frame too short");
   load_gap_a:
      assert property ($fell(loadOutputStrobeN) && dacFrm_r |->
         hiCnt_r >= 13'(dsf_pkg::DAC_GAP_CYC))
      else $error("load strobe too early");
   strobe_outside_a:
      assert property ($fell(loadOutputStrobeN) |-> frameSelN)
      else $error("load strobe inside a frame");
   clock_idle_a:
      assert property (frameSelN && $past(frameSelN) |-> $stable(serialClk))
      else $error("serial clock moved between frames");
   data_setup_a:
      assert property ($fell(serialClk) && !frameSelN |-> $stable(serialIn))
      else $error("data moved at sampling edge");
   out_valid_a:
      assert property ($changed(serialOut) && !frameSelN |-> age_r <= 4'h7)
      else $error("readback bit late after clock rise");

   cover property ($rose(frameSelN) && fallCnt_r == dsf_pkg::FRAME_LEN_PEC);
   cover property ($fell(loadOutputStrobeN) && dacFrm_r);
   cover property ($changed(serialOut) && !frameSelN);
endmodule : dsf_assertions

// ==== verification/dac_serial_frame_timing_test.sv ====
`timescale 1ns/1ps
module dac_serial_frame_timing_test;
   typedef struct packed {
      logic [4:0]  ctrl;
      logic [23:0] word;
      logic [1:0]  kind;
      logic [12:0] gap;
      logic [31:0] exp;
   } dsf_row_t;
   localparam logic [15:0] RD = 16'hC3A5;
   logic        sys_clk, reset_n, cyc, stb, we, ack, irq, pecOn, dacUpd, cfgV2;
   logic        prevSel, prevStb, heldOn, pecErr;
   logic [3:0]  sel;
   logic [7:0]  adr;
   logic [31:0] datI, datO, q;
   logic [15:0] dacCode;
   logic [23:0] cfgWord, cfgWord2;
   dsf_row_t    rows [9];
   int          num_errors, n_tests, cycles, nV2, selAge, stbAge, gapNeed, curGap;

   dsf_if dsf_if_i ();
   dsf_if fault_if_i ();
   dsf_host dsf_host_i (.sys_clk(sys_clk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack),
      .irq(irq), .link(dsf_if_i.host));
   dsf_device dsf_device_i (.sys_clk(sys_clk), .reset_n(reset_n), .link(dsf_if_i.dev),
      .pecEnable(pecOn), .readData(RD), .dacCode(dacCode), .dacUpdated(dacUpd),
      .cfgWord(cfgWord), .cfgValid(), .pecError(pecErr));
   // second device faces the bench so that broken frames can be sent on purpose
   dsf_device fault_device_i (.sys_clk(sys_clk), .reset_n(reset_n),
      .link(fault_if_i.dev), .pecEnable(1'b0), .readData(16'h0000), .dacCode(),
      .dacUpdated(), .cfgWord(cfgWord2), .cfgValid(cfgV2), .pecError());
   dsf_assertions dsf_assertions_i (.sys_clk(sys_clk), .reset_n(reset_n),
      .serialClk(dsf_if_i.serialClk), .frameSelN(dsf_if_i.frameSelN),
      .serialIn(dsf_if_i.serialIn), .serialOut(dsf_if_i.serialOut),
      .loadOutputStrobeN(dsf_if_i.loadOutputStrobeN));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      t = 0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      q = datO;
      if (t == 50) chk("ack", 32'h0, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic waitReady();
      int t;
      t = 0;
      while (irq !== 1'b1 && t < 9000) begin
         @(posedge sys_clk);
         t++;
      end
      if (t == 9000) chk("ready", 32'h0, 32'h1);
      wb(1'b0, dsf_pkg::REG_STAT, 32'h0);
      @(posedge sys_clk);
      chk("irqClear", 32'(irq), 32'h0);
   endtask : waitReady

   // 25 cycle link clock; data moves only while the clock is high
   task automatic rawFrame(input int n, input logic [23:0] w);
      fault_if_i.frameSelN <= 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (6) @(posedge sys_clk);
         fault_if_i.serialIn <= w[23-i];
         repeat (7) @(posedge sys_clk);
         fault_if_i.serialClk <= 1'b0;
         repeat (12) @(posedge sys_clk);
         fault_if_i.serialClk <= 1'b1;
      end
      repeat (6) @(posedge sys_clk);
      fault_if_i.frameSelN <= 1'b1;
      fault_if_i.serialIn <= ~fault_if_i.serialIn;
      repeat (60) @(posedge sys_clk);
   endtask : rawFrame

   function automatic logic [7:0] crcOf(input logic [15:0] v);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction : crcOf

   always @(posedge sys_clk) begin
      if (dsf_if_i.frameSelN && !prevSel) gapNeed <= curGap;
      if (!dsf_if_i.frameSelN && prevSel) chk("gap", 32'(selAge >= gapNeed), 32'h1);
      if (!dsf_if_i.loadOutputStrobeN && prevStb && !heldOn)
         chk("loadGap", 32'(selAge >= gapNeed), 32'h1);
      if (dacUpd && heldOn && dsf_if_i.clearN)
         chk("heldResp", 32'(selAge >= 1000 && selAge <= 1015), 32'h1);
      if (dacUpd && !heldOn && dsf_if_i.clearN) chk("resp", 32'(stbAge <= 100), 32'h1);
      if (pecErr) chk("pecErr", 32'h1, 32'h0);
      if (cfgV2) nV2 <= nV2 + 1;
      selAge <= dsf_if_i.frameSelN ? selAge + 1 : 0;
      stbAge <= (prevStb && !dsf_if_i.loadOutputStrobeN) ? 0 : stbAge + 1;
      prevSel <= dsf_if_i.frameSelN;
      prevStb <= dsf_if_i.loadOutputStrobeN;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      {reset_n, cyc, stb, we, pecOn, heldOn, nV2, cycles, num_errors, n_tests} = '0;
      {sel, adr, datI, gapNeed, curGap} = '0;
      {prevSel, prevStb, selAge, stbAge} = {2'b11, 32'd5000, 32'd5000};
      {fault_if_i.serialClk, fault_if_i.frameSelN, fault_if_i.serialIn} = 3'b110;
      {fault_if_i.loadOutputStrobeN, fault_if_i.clearN} = 2'b11;
      rows[0] = '{5'h00, 24'h12_3456, 2'h0, 13'h0028, 32'h0012_3456};
      rows[1] = '{5'h01, 24'h05_A5A5, 2'h0, 13'h0028, 32'h0005_A5A5};
      rows[2] = '{5'h04, 24'h40_1234, 2'h1, 13'h03E8, 32'h0000_1234};
      rows[3] = '{5'h08, 24'h40_BEEF, 2'h1, 13'h03E8, 32'h0000_BEEF};
      rows[4] = '{5'h0A, 24'h40_0F0F, 2'h1, 13'h0FA0, 32'h0000_0F0F};
      rows[5] = '{5'h00, 24'h80_0000, 2'h3, 13'h0028, 32'h0000_0000};
      rows[6] = '{5'h00, 24'h00_0000, 2'h2, 13'h0028, {15'h0000, RD, 1'b0}};
      rows[7] = '{5'h01, 24'h80_0000, 2'h3, 13'h0028, 32'h0000_0000};
      rows[8] = '{5'h01, 24'h00_0000, 2'h2, 13'h0028, {7'h00, RD, crcOf(RD), 1'b0}};
      sel = 4'hF;
      repeat (2) @(posedge sys_clk);
      chk("reset", 32'({dacCode, ack, irq, dsf_if_i.serialClk, dsf_if_i.frameSelN,
         dsf_if_i.loadOutputStrobeN, dsf_if_i.clearN}), 32'h0000_000F);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      wb(1'b1, dsf_pkg::REG_MASK, 32'h2);
      foreach (rows[i]) begin
         pecOn <= rows[i].ctrl[0];
         heldOn = rows[i].ctrl[2];
         curGap = int'(rows[i].gap);
         wb(1'b1, dsf_pkg::REG_CTRL, 32'(rows[i].ctrl));
         wb(1'b1, dsf_pkg::REG_TX, 32'(rows[i].word));
         waitReady();
         chk("stat", q, 32'h3);
         repeat (100) @(posedge sys_clk);
         if (rows[i].kind == 2'h0) chk("cfg", 32'(cfgWord), rows[i].exp);
         if (rows[i].kind == 2'h1) chk("dac", 32'(dacCode), rows[i].exp);
         if (rows[i].kind == 2'h2) begin
            wb(1'b0, dsf_pkg::REG_RX, 32'h0);
            chk("readback", q, rows[i].exp);
         end
      end
      // second start while busy must be dropped
      pecOn <= 1'b0;
      heldOn = 1'b0;
      curGap = 40;
      wb(1'b1, dsf_pkg::REG_CTRL, 32'h0);
      wb(1'b1, dsf_pkg::REG_TX, 32'h0011_1111);
      wb(1'b1, dsf_pkg::REG_TX, 32'h0022_2222);
      waitReady();
      repeat (1500) @(posedge sys_clk);
      chk("busyDrop", 32'(cfgWord), 32'h0011_1111);
      wb(1'b0, 8'h20, 32'hFFFF_FFFF);
      chk("unmapped", q, 32'h0);
      // masked event stays silent until unmasked
      wb(1'b1, dsf_pkg::REG_MASK, 32'h0);
      wb(1'b1, dsf_pkg::REG_TX, 32'h0033_0000);
      repeat (1500) @(posedge sys_clk);
      chk("masked", 32'(irq), 32'h0);
      wb(1'b1, dsf_pkg::REG_MASK, 32'h2);
      chk("unmasked", 32'(irq), 32'h1);
      waitReady();
      chk("statMask", q, 32'h3);
      wb(1'b1, dsf_pkg::REG_CTRL, 32'h10);
      repeat (20) @(posedge sys_clk);
      chk("clear", 32'({dsf_if_i.clearN, dacCode}), 32'h0);
      rawFrame(23, 24'h31_2468);
      chk("shortFrame", 32'(nV2), 32'h0);
      rawFrame(24, 24'h31_2468);
      chk("fullFrame", {8'(nV2), cfgWord2}, 32'h0131_2468);
      summarize();
   end
endmodule : dac_serial_frame_timing_test
